// >>> hw/ccb_pkg.sv
package ccb_pkg;
    // ==========================================================
    // Register map.
    localparam logic [7:0] CCB_OFS_CTRL = 8'h00;
    localparam logic [7:0] CCB_OFS_EDGE = 8'h04;
    localparam logic [7:0] CCB_OFS_PINSEL = 8'h08;
    localparam logic [7:0] CCB_OFS_STATUS = 8'h0C;
    localparam logic [7:0] CCB_OFS_MASK = 8'h10;
    localparam logic [7:0] CCB_OFS_LEVEL = 8'h14;
    // ==========================================================
    // Field positions and reset values.
    localparam int CCB_HYST_LSB = 4;
    localparam int CCB_ON_LSB = 0;
    localparam logic [7:0] CCB_CTRL_RST = 8'hF0;
    localparam logic [1:0] CCB_EDGE_RST = 2'h3;
    localparam logic [7:0] CCB_PINSEL_RST = 8'h00;
    localparam logic [1:0] CCB_CPN_SEL = 2'h2;
    localparam int CCB_CPN_LSB = 2;
    localparam int CCB_ST_ADC = 0;
    localparam int CCB_ST_COMP0 = 1;
    localparam logic [1:0] CCB_AXI_OKAY = 2'h0;
    localparam logic [1:0] CCB_AXI_SLVERR = 2'h2;
    // ==========================================================
    // Comparator 0 edge modes.
    typedef enum logic [1:0] {
        CCB_EDGE_OFF = 2'b00,
        CCB_EDGE_RISE = 2'b01,
        CCB_EDGE_FALL = 2'b10,
        CCB_EDGE_BOTH = 2'b11
    } ccb_edge_t;
endpackage

// >>> hw/ccb_sync.sv
module ccb_sync (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Asynchronous comparator outputs and their synchronised copies.
    input wire logic [3:0] async_in,
    output logic [3:0] sync_out
);
    import ccb_pkg::*;

    typedef struct packed {
        logic [3:0] first;
        logic [3:0] second;
    } ccb_sync_t;

    ccb_sync_t state;
    ccb_sync_t next_state;

    // ==========================================================
    // Two stage synchroniser; the first stage feeds only the second.
    always_comb begin
        next_state = state;
        next_state.first = async_in;
        next_state.second = state.first; // R12
    end

    // Register the stages.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.second;
endmodule

// >>> hw/ccb_edge.sv
module ccb_edge (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Synchronised comparator 0 level and edge mode.
    input wire logic level,
    input wire ccb_pkg::ccb_edge_t mode,
    // Detected edge pulse and protection trigger pulse.
    output logic edge_hit,
    output logic trip_hit
);
    import ccb_pkg::*;

    typedef struct packed {
        logic last;
    } ccb_edge_state_t;

    ccb_edge_state_t state;
    ccb_edge_state_t next_state;
    logic rise;
    logic fall;

    // ==========================================================
    // Remember the previous level to find edges.
    always_comb begin
        next_state = state;
        next_state.last = level;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign rise = level & ~state.last;
    assign fall = ~level & state.last;

    // Dual edge interrupts but never trips the drive.
    always_comb begin
        case (mode)
            CCB_EDGE_RISE: begin
                edge_hit = rise; // R11
                trip_hit = rise;
            end
            CCB_EDGE_FALL: begin
                edge_hit = fall; // R11
                trip_hit = fall;
            end
            CCB_EDGE_BOTH: begin
                edge_hit = rise | fall; // R11
                trip_hit = 1'b0;
            end
            default: begin
                edge_hit = 1'b0; // R11
                trip_hit = 1'b0;
            end
        endcase
    end
endmodule

// >>> hw/ccb_top.sv
// Summary of operation
// R1 - Bits 7..4 hold hysteresis enables for comparators 3..0, reset to one.
// R2 - Bits 3..0 hold on/off enables for comparators 3..0, reset to zero.
// R3 - A cleared on/off enable powers its comparator fully down.
// R4 - A set hysteresis enable applies hysteresis, clear applies none.
// R5 - Pin-share field value 10 ties negative inputs 1..3 to common pin.
// R6 - Pull-high resistors drop off pins whose comparator function is chosen.
// R7 - Software selects comparator pin functions before use.
// R8 - Software should turn unused comparators off before idle or sleep.
// R9 - Two interrupt sources: ADC limit and comparator 0.
// R10 - An over-current trip switches the motor drive off at once.
// R11 - Edge field: 00 off, 01 rise, 10 fall, 11 both without trip.
// R12 - Comparator outputs pass two flip-flops before edge detection.
module ccb_top (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Analog comparator interface.
    input wire logic [3:0] comp_out,
    output logic [3:0] comp_power,
    output logic [3:0] comp_hyst,
    output logic dac0_enable,
    output logic neg_short_enable,
    output logic [3:0] pull_high_off,
    // Over-current path.
    input wire logic adc_limit_event,
    output logic drive_kill,
    output logic irq
);
    import ccb_pkg::*;

    // ==========================================================
    // State of the block.
    // Everything that the block remembers outside u_sync and u_edge sits in one packed struct, so
    // the reset value and the next-state default are written only once.
    typedef struct packed {
        // Software-visible registers.
        logic [7:0] comparator_control;
        logic [1:0] edge_sel;
        logic [7:0] pin_share_sel_b;
        logic [1:0] status;
        logic [1:0] mask;
        // Write channel holding registers; either channel may come first.
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        // Registered bus answers.
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        // Registered analog and protection controls.
        logic [3:0] power;
        logic [3:0] hyst;
        logic dac_en;
        logic short_en;
        logic [3:0] pull_off;
        logic kill;
    } ccb_state_t;

    ccb_state_t state;
    ccb_state_t next_state;

    // Synchronised levels, edge pulses and the bus strobes derived below.
    logic [3:0] comp_sync;
    logic edge_hit;
    logic trip_hit;
    logic do_write;
    logic do_read;
    logic [1:0] events;

    // Map an address to whether it names a register.
    // The level word is mapped but read-only; a write to it is answered
    // with OKAY and changes nothing.
    function automatic logic ccb_mapped(input logic [7:0] a);
        ccb_mapped = (a == CCB_OFS_CTRL) || (a == CCB_OFS_EDGE) ||
                     (a == CCB_OFS_PINSEL) || (a == CCB_OFS_STATUS) ||
                     (a == CCB_OFS_MASK) || (a == CCB_OFS_LEVEL);
    endfunction

    // Merge byte lane zero of a write into an 8-bit register.
    // Only the low lane carries bits, so the upper strobes are ignored.
    function automatic logic [7:0] ccb_lane0(input logic [7:0] old,
                                              input logic [31:0] d,
                                              input logic [3:0] s);
        ccb_lane0 = s[0] ? d[7:0] : old;
    endfunction

    // ==========================================================
    // Comparator output synchronisers and the comparator 0 edge logic.
    ccb_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(comp_out),
        .sync_out(comp_sync)
    );

    // Edge detection tracks the level in every mode, so switching the
    // mode on later cannot compare against a stale level and raise a
    // false edge.
    ccb_edge u_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .level(comp_sync[0]),
        .mode(ccb_edge_t'(state.edge_sel)),
        .edge_hit(edge_hit),
        .trip_hit(trip_hit)
    );

    // Handshake outputs are combinational on the holding flags.
    // A write is refused while its response waits, which keeps one write
    // outstanding and lets the commit use the held copies only.
    assign s_axi_awready = ~state.aw_held & ~state.bvalid;
    assign s_axi_wready = ~state.w_held & ~state.bvalid;
    assign s_axi_arready = ~state.rvalid;
    assign do_write = state.aw_held & state.w_held & ~state.bvalid;
    assign do_read = s_axi_arvalid & ~state.rvalid;
    // Bit 0 is the ADC limit event, bit 1 the comparator 0 edge.
    assign events = {edge_hit, adc_limit_event}; // R9

    // ==========================================================
    // Next state: bus slave, registers, events and analog controls.
    always_comb begin
        next_state = state;
        // Address and data may arrive in either order; each is held.
        if (s_axi_awvalid && s_axi_awready) begin
            next_state.aw_held = 1'b1;
            next_state.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_state.w_held = 1'b1;
            next_state.w_data = s_axi_wdata;
            next_state.w_strb = s_axi_wstrb;
        end

        // A write commits one cycle after both halves are held, and its
        // response then stands until the master takes it.
        // Status clears by writing one; a set in the same cycle wins.
        if (do_write) begin
            next_state.aw_held = 1'b0;
            next_state.w_held = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp = ccb_mapped(state.aw_addr) ?
                               CCB_AXI_OKAY : CCB_AXI_SLVERR;
            case (state.aw_addr)
                CCB_OFS_CTRL: begin
                    next_state.comparator_control = ccb_lane0(
                        state.comparator_control, state.w_data,
                        state.w_strb); // R1 R2
                end
                CCB_OFS_EDGE: begin
                    if (state.w_strb[0]) begin
                        next_state.edge_sel = state.w_data[1:0]; // R11
                    end
                end
                CCB_OFS_PINSEL: begin
                    next_state.pin_share_sel_b = ccb_lane0(
                        state.pin_share_sel_b, state.w_data, state.w_strb);
                end
                CCB_OFS_STATUS: begin
                    if (state.w_strb[0]) begin
                        next_state.status = state.status &
                                            ~state.w_data[1:0];
                    end
                end
                CCB_OFS_MASK: begin
                    if (state.w_strb[0]) begin
                        next_state.mask = state.w_data[1:0];
                    end
                end
                default: begin
                    // The level word and unmapped places keep every bit.
                    next_state.bresp = next_state.bresp;
                end
            endcase
        end
        // Events are merged after the clear so a new event is never lost.
        next_state.status = next_state.status | events;
        if (state.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end

        // Reads answer one cycle after the address is taken.
        if (do_read) begin
            next_state.rvalid = 1'b1;
            next_state.rresp = ccb_mapped(s_axi_araddr) ?
                               CCB_AXI_OKAY : CCB_AXI_SLVERR;
            case (s_axi_araddr)
                CCB_OFS_CTRL: begin
                    next_state.rdata = {24'h000000,
                                        state.comparator_control};
                end
                CCB_OFS_EDGE: begin
                    next_state.rdata = {30'h00000000, state.edge_sel};
                end
                CCB_OFS_PINSEL: begin
                    next_state.rdata = {24'h000000, state.pin_share_sel_b};
                end
                CCB_OFS_STATUS: begin
                    next_state.rdata = {30'h00000000, state.status};
                end
                CCB_OFS_MASK: begin
                    next_state.rdata = {30'h00000000, state.mask};
                end
                CCB_OFS_LEVEL: begin
                    next_state.rdata = {28'h0000000, comp_sync};
                end
                default: begin
                    next_state.rdata = 32'h00000000;
                end
            endcase
        end else if (state.rvalid && s_axi_rready) begin
            next_state.rvalid = 1'b0;
        end

        // Analog controls follow the registers by one cycle.
        // The extra flop keeps every analog switch free of decode glitches,
        // at the cost of one cycle between a write and its effect.
        next_state.power = state.comparator_control[CCB_ON_LSB +: 4]; // R3
        next_state.hyst = state.comparator_control[CCB_HYST_LSB +: 4]; // R4
        next_state.dac_en = (state.edge_sel != CCB_EDGE_OFF); // R11
        next_state.short_en = (state.pin_share_sel_b[CCB_CPN_LSB +: 2] ==
                               CCB_CPN_SEL); // R5

        // A nonzero pin-share pair means that pin carries a comparator.
        for (int i = 0; i < 4; i++) begin
            next_state.pull_off[i] =
                |state.pin_share_sel_b[2 * i +: 2]; // R6
        end

        // The trip latches so a brief pulse cannot be missed by the drive.
        // Writing the edge field to off is the only way to rearm it, so
        // software alone decides when the motor may run again.
        if (trip_hit) begin
            next_state.kill = 1'b1; // R10
        end else if (state.edge_sel == CCB_EDGE_OFF) begin
            next_state.kill = 1'b0;
        end
    end

    // ==========================================================
    // Register the state.
    // Reset loads the documented register values; the analog controls
    // are loaded to match them so no output changes after release.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
            state.comparator_control <= CCB_CTRL_RST; // R1 R2
            state.edge_sel <= CCB_EDGE_RST;
            state.pin_share_sel_b <= CCB_PINSEL_RST;
            state.hyst <= CCB_CTRL_RST[CCB_HYST_LSB +: 4];
            state.dac_en <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Outputs.
    assign s_axi_bvalid = state.bvalid;
    assign s_axi_bresp = state.bresp;
    assign s_axi_rvalid = state.rvalid;
    assign s_axi_rdata = state.rdata;
    assign s_axi_rresp = state.rresp;

    // Analog controls come straight from flip-flops, one per function.
    assign comp_power = state.power;
    assign comp_hyst = state.hyst;
    assign dac0_enable = state.dac_en;
    assign neg_short_enable = state.short_en;
    assign pull_high_off = state.pull_off;

    // The trip pulse is or-ed in so the drive stops in the cycle of the
    // edge itself rather than one cycle later.
    assign drive_kill = state.kill | trip_hit; // R10
    // The interrupt is a level that stays high while an unmasked cause is pending.
    assign irq = |(state.status & state.mask);
endmodule

// >>> dv/ccb_properties.sv
module ccb_props
    import ccb_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Comparator and over-current side.
    input wire logic [3:0] comp_out,
    input wire logic [3:0] comp_power,
    input wire logic [3:0] comp_hyst,
    input wire logic dac0_enable,
    input wire logic neg_short_enable,
    input wire logic [3:0] pull_high_off,
    input wire logic adc_limit_event,
    input wire logic drive_kill,
    input wire logic irq
);
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_low;
    logic wr_new;
    // ==========================================================
    // Last accepted write; it cannot change while bvalid is up.
    always_ff @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready) wr_addr <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) wr_data <= s_axi_wdata[7:0];
        if (s_axi_wvalid && s_axi_wready) wr_low <= s_axi_wstrb[0];
    end
    assign wr_new = wr_low;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========================================================
    // Outputs follow the registers one cycle after the commit.
    a_reset_values: assert property ($rose(aresetn) |->
        comp_power == 4'h0 && comp_hyst == 4'hF && dac0_enable && !drive_kill
        && !irq && pull_high_off == 4'h0 && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs wrong after reset");
    a_ctrl_outputs: assert property ($rose(s_axi_bvalid) && wr_new
        && wr_addr == CCB_OFS_CTRL |=> comp_power == wr_data[3:0]
        && comp_hyst == wr_data[7:4]) else $error("ctrl outputs wrong");
    a_pin_share: assert property ($rose(s_axi_bvalid) && wr_new
        && wr_addr == CCB_OFS_PINSEL |=> neg_short_enable ==
        (wr_data[3:2] == CCB_CPN_SEL) && pull_high_off == {|wr_data[7:6],
        |wr_data[5:4], |wr_data[3:2], |wr_data[1:0]})
        else $error("pin share outputs wrong");
    a_edge_mode: assert property ($rose(s_axi_bvalid) && wr_new
        && wr_addr == CCB_OFS_EDGE |=> dac0_enable == (wr_data[1:0] != 2'h0)
        && (wr_data[1:0] != 2'h0 || !drive_kill))
        else $error("edge mode outputs wrong");
    a_irq_cause: assert property ($rose(irq) |->
        $past(adc_limit_event) || $rose(s_axi_bvalid)
        || $past(comp_out[0], 3) != $past(comp_out[0], 4)
        || $past(comp_out[0], 4) != $past(comp_out[0], 5))
        else $error("irq rose without a cause");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready) else $error("read answer late");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
    a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("response moved");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready
        && !s_axi_wready) else $error("write taken during response");
    // ==========================================================
    // Main scenarios.
    c_trip: cover property ($rose(drive_kill));
    c_irq: cover property ($rose(irq));
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == CCB_AXI_SLVERR);
endmodule

bind ccb_top ccb_props u_props (.*);

// >>> dv/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ccb_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, adc_ev = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, p, ctl;
    logic [31:0] wdata = 32'h0, v, lf = 32'hA431;
    logic [3:0] wstrb = 4'h0, comp_out = 4'h0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, dac_en, short_en;
    logic kill_out, irq, ha, hw, hb, hit, kill;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata;
    logic [3:0] power, hyst, pull_off;
    int n_fail = 0, num_checks = 0;
    // Register model: expected word and implemented width per register;
    // a width of zero marks a word that hardware changes by itself.
    int mdl [6] = '{int'(CCB_CTRL_RST), int'(CCB_EDGE_RST),
        int'(CCB_PINSEL_RST), 0, 0, 0};
    int wid [6] = '{8, 2, 8, 0, 2, 0};
    // ==========================================================
    // Clock and the design.
    always #12.5 aclk = ~aclk;
    ccb_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .comp_out(comp_out), .comp_power(power),
        .comp_hyst(hyst), .dac0_enable(dac_en), .neg_short_enable(short_en),
        .pull_high_off(pull_off), .adc_limit_event(adc_ev),
        .drive_kill(kill_out), .irq(irq));
    // ==========================================================
    // Helpers; ready is raised late so the slave must hold its answer.
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] er);
        @(posedge aclk);
        lf = lfsr(lf);
        awaddr <= a;
        wdata <= {lf[31:8], d};
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        hb = 1'b0;
        while (!hb) begin
            @(negedge aclk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid && bready;
            r = bresp;
            @(posedge aclk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            bready <= bvalid && !hb;
        end
        chk("write done", 32'(!awvalid && !wvalid), 32'h1);
        chk("bresp", 32'(r), 32'(er));
        if (a < 8'h18 && wid[a >> 2] > 0)
            mdl[a >> 2] = int'(d) & ((1 << wid[a >> 2]) - 1);
        @(negedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        hb = 1'b0;
        while (!hb) begin
            @(negedge aclk);
            ha = arvalid && arready;
            hb = rvalid && rready;
            r = rresp;
            v = rdata;
            @(posedge aclk);
            if (ha) arvalid <= 1'b0;
            rready <= rvalid && !hb;
        end
        chk("read done", 32'(!arvalid), 32'h1);
        chk("rresp", 32'(r), 32'(er));
        if (a < 8'h18 && wid[a >> 2] > 0)
            chk("model", v, 32'(mdl[a >> 2]));
        @(negedge aclk);
    endtask
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ==========================================================
    // Hang guard, far beyond the few hundred cycles of the run.
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        give_verdict();
    end
    // ==========================================================
    // Main sequence.
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(CCB_OFS_CTRL, CCB_AXI_OKAY);
        chk("ctrl", v, 32'hF0);
        chk("hyst", 32'(hyst), 32'hF);
        chk("power", 32'(power), 32'h0);
        rd(CCB_OFS_EDGE, CCB_AXI_OKAY);
        chk("edge", v, 32'h3);
        for (int i = 0; i < 6; i++) begin
            ctl = lf[15:8];
            wr(CCB_OFS_CTRL, ctl, CCB_AXI_OKAY);
            rd(CCB_OFS_CTRL, CCB_AXI_OKAY);
            chk("ctrl", v, 32'(ctl));
            chk("power", 32'(power), 32'(ctl[3:0]));
            chk("hyst", 32'(hyst), 32'(ctl[7:4]));
        end
        for (int f = 0; f < 4; f++) begin
            p = lf[7:0];
            p[3:2] = f[1:0];
            wr(CCB_OFS_PINSEL, p, CCB_AXI_OKAY);
            chk("short", 32'(short_en), 32'(f == 2));
            chk("pull off", 32'(pull_off), 32'({|p[7:6], |p[5:4],
                |p[3:2], |p[1:0]}));
        end
        // Route comparator 0 to its pins and power it before using it.
        wr(CCB_OFS_PINSEL, 8'h03, CCB_AXI_OKAY);
        chk("pull off", 32'(pull_off), 32'h1);
        ctl = ctl | 8'h01;
        wr(CCB_OFS_CTRL, ctl, CCB_AXI_OKAY);
        chk("power", 32'(power), 32'(ctl[3:0]));
        wr(CCB_OFS_MASK, 8'h03, CCB_AXI_OKAY);
        for (int m = 0; m < 4; m++) begin
            wr(CCB_OFS_EDGE, 8'h00, CCB_AXI_OKAY);
            kill = 1'b0;
            wr(CCB_OFS_EDGE, 8'(m), CCB_AXI_OKAY);
            chk("dac", 32'(dac_en), 32'(m != 0));
            for (int e = 0; e < 2; e++) begin
                @(posedge aclk);
                comp_out <= {lf[3:1], !e[0]};
                repeat (5) @(negedge aclk);
                hit = (m == 3) || (m == e + 1);
                kill = kill || (hit && m != 3);
                rd(CCB_OFS_LEVEL, CCB_AXI_OKAY);
                chk("level", v, 32'(comp_out));
                rd(CCB_OFS_STATUS, CCB_AXI_OKAY);
                chk("status", v, 32'(hit) << 1);
                chk("irq", 32'(irq), 32'(hit));
                chk("kill", 32'(kill_out), 32'(kill));
                wr(CCB_OFS_STATUS, 8'h02, CCB_AXI_OKAY);
            end
        end
        @(posedge aclk);
        adc_ev <= 1'b1;
        @(posedge aclk);
        adc_ev <= 1'b0;
        wr(CCB_OFS_MASK, 8'h02, CCB_AXI_OKAY);
        rd(CCB_OFS_STATUS, CCB_AXI_OKAY);
        chk("status", v, 32'h1);
        chk("irq", 32'(irq), 32'h0);
        wr(CCB_OFS_MASK, 8'h01, CCB_AXI_OKAY);
        chk("irq", 32'(irq), 32'h1);
        wr(CCB_OFS_STATUS, 8'h01, CCB_AXI_OKAY);
        chk("irq", 32'(irq), 32'h0);
        // An unmapped place is refused and leaves the control word alone.
        wr(8'h18, 8'h0F, CCB_AXI_SLVERR);
        rd(8'h18, CCB_AXI_SLVERR);
        chk("unmapped", v, 32'h0);
        rd(CCB_OFS_CTRL, CCB_AXI_OKAY);
        chk("ctrl", v, 32'(ctl));
        // All comparators off again, as before the part would go idle.
        wr(CCB_OFS_CTRL, 8'hF0, CCB_AXI_OKAY);
        chk("power", 32'(power), 32'h0);
        give_verdict();
    end
endmodule
